// ===== ssu_assertions.sv
// Port checks for the security sector and unique ID block
`default_nettype none

module ssu_checker #(
  parameter int WRITE_CYCLES = ssu_pkg::WRITE_CYCLES
) (
  input  wire logic mclk_i,
  input  wire logic reset_i,
  input  wire logic spi_cs_n_i,
  input  wire logic serial_out_oe_n_o,
  input  wire logic block_protect_hi_i,
  input  wire logic block_protect_lo_i,
  input  wire logic nv_lock_i,
  input  wire logic write_enable_latch_o,
  input  wire logic write_in_progress_o,
  input  wire logic sector_locked_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  // Length of the current busy stretch; a range allows for the registered start and done lag of the timer
  int busy_q;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) busy_q <= 0;
    else if (write_in_progress_o) busy_q <= busy_q + 1;
    else busy_q <= 0;
  end

  oe_release_a: assert property (spi_cs_n_i |-> serial_out_oe_n_o)
    else $error("data out enabled while deselected");
  busy_len_a: assert property ($fell(write_in_progress_o) |-> busy_q >= WRITE_CYCLES && busy_q <= WRITE_CYCLES + 2)
    else $error("write cycle length wrong");
  latch_clear_a: assert property ($fell(write_in_progress_o) |-> !write_enable_latch_o)
    else $error("write latch kept after cycle");
  latch_gate_a: assert property ($rose(write_in_progress_o) |-> write_enable_latch_o && spi_cs_n_i)
    else $error("write cycle without latch or inside frame");
  lock_keep_a: assert property (sector_locked_o |=> sector_locked_o)
    else $error("lock cleared");
  // The edge that releases reset still runs the reset branch, so the reload is one cycle later
  lock_load_a: assert property (nv_lock_i && !$past(reset_i) |=> sector_locked_o)
    else $error("stored lock not loaded");
  protect_block_a: assert property ((block_protect_hi_i && block_protect_lo_i) [*4] |-> !$rose(write_in_progress_o))
    else $error("write cycle under full protection");
  locked_block_a: assert property (sector_locked_o [*4] |-> !$rose(write_in_progress_o))
    else $error("write cycle while locked");
  busy_read_a: assert property (write_in_progress_o [*8] |-> serial_out_oe_n_o)
    else $error("read answered during write cycle");

  busy_c: cover property ($rose(write_in_progress_o));
  lock_c: cover property ($rose(sector_locked_o));
  drive_c: cover property ($fell(serial_out_oe_n_o));
endmodule : ssu_checker

bind ssu_top ssu_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_ssu_checker (
  .mclk_i(mclk_i),
  .reset_i(reset_i),
  .spi_cs_n_i(spi_cs_n_i),
  .serial_out_oe_n_o(serial_out_oe_n_o),
  .block_protect_hi_i(block_protect_hi_i),
  .block_protect_lo_i(block_protect_lo_i),
  .nv_lock_i(nv_lock_i),
  .write_enable_latch_o(write_enable_latch_o),
  .write_in_progress_o(write_in_progress_o),
  .sector_locked_o(sector_locked_o)
);

`default_nettype wire

// ===== ssu_host.sv
// Serial host model that drives frames into the block
`default_nettype none

module ssu_host (
  output logic      spi_clk_o,
  output logic      spi_cs_n_o,
  output logic      serial_in_o,
  input  wire logic serial_out_i
);
  timeunit 1ns;
  timeprecision 100ps;

  // Clock idles low and stands still between frames
  initial begin
    spi_clk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    serial_in_o = 1'b0;
  end

  // Odd offset keeps the link phase apart from the system clock
  task automatic start();
    #3;
    spi_cs_n_o = 1'b0;
    #20;
  endtask : start

  task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < n; i++) begin
      serial_in_o = tx[7 - i];
      #6;
      spi_clk_o = 1'b1;
      rx = {rx[6:0], serial_out_i};
      #6;
      spi_clk_o = 1'b0;
    end
  endtask : shift

  // Select rises before any further clock edge; released data shows the inverse
  task automatic stop();
    #4;
    spi_cs_n_o = 1'b1;
    serial_in_o = ~serial_in_o;
    #240;
  endtask : stop
endmodule : ssu_host

`default_nettype wire

// ===== ssu_pkg.sv
// Constants and types shared by the security sector and unique ID block
`default_nettype none

package ssu_pkg;

  localparam logic [7:0] OP_SET_WRITE_LATCH   = 8'h06;
  localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] OP_SECTOR_READ       = 8'h83;
  localparam logic [7:0] OP_SECTOR_WRITE      = 8'h82;

  localparam logic [1:0] SEL_SECTOR = 2'h0;
  localparam logic [1:0] SEL_LOCK   = 2'h2;

  localparam int         OP_BITS      = 8;
  localparam int         HEADER_BITS  = 24;
  localparam int         LOCK_BITS    = 32;
  localparam logic [5:0] CNT_OPCODE   = 6'h07;
  localparam logic [5:0] CNT_ADDR     = 6'h17;
  localparam logic [5:0] CNT_SAT      = 6'h21;
  localparam logic [5:0] CNT_CMD_ONLY = 6'h08;
  localparam logic [5:0] CNT_HEADER   = 6'h18;
  localparam logic [5:0] CNT_ONE_BYTE = 6'h20;
  localparam logic [2:0] PHASE_LAST   = 3'h7;

  localparam int SECTOR_BYTES = 32;
  localparam int UID_BYTES    = 16;
  localparam int UID_WIDTH    = 128;
  localparam int LOCK_BIT_POS = 1;

  localparam int WRITE_TIME_MS = 5;
  localparam int CLK_HZ        = 25000000;
  localparam int WRITE_CYCLES  = WRITE_TIME_MS * (CLK_HZ / 1000);

  typedef enum logic [2:0] {
    SSU_MODE_NONE     = 3'h0,
    SSU_MODE_SEC_RD   = 3'h1,
    SSU_MODE_LOCK_RD  = 3'h2,
    SSU_MODE_UID_RD   = 3'h3,
    SSU_MODE_SEC_WR   = 3'h4,
    SSU_MODE_LOCK_WR  = 3'h5
  } ssu_mode_t;

endpackage : ssu_pkg

`default_nettype wire

// ===== ssu_sync.sv
// Two-flop level synchroniser
`default_nettype none

module ssu_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic level_i,
  output logic      level_o
);

  logic meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_q  <= RESET_VAL;
      level_o <= RESET_VAL;
    end else begin
      meta_q  <= level_i;
      level_o <= meta_q;
    end
  end

endmodule : ssu_sync

`default_nettype wire

// ===== ssu_timer.sv
// Self-timed write cycle counter
`default_nettype none

module ssu_timer #(
  parameter int CYCLES = 125000
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic start_i,
  output logic      done_o
);

  logic [31:0] cnt_q;
  logic        run_q;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q  <= 32'h0000_0000;
      run_q  <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        cnt_q <= 32'(CYCLES - 1);
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q == 32'h0000_0000) begin
          run_q  <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 32'h0000_0001;
        end
      end
    end
  end

endmodule : ssu_timer

`default_nettype wire

// ===== ssu_top.sv
// Security sector, lock and unique ID instruction handling
`default_nettype none

module ssu_top #(
  parameter int               WRITE_CYCLES = ssu_pkg::WRITE_CYCLES,
  parameter logic [127:0]     UID_VALUE    = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210
) (
  input  wire logic mclk_i,
  input  wire logic reset_i,
  input  wire logic spi_clk_i,
  input  wire logic spi_cs_n_i,
  input  wire logic serial_in_i,
  output logic      serial_out_o,
  output logic      serial_out_oe_n_o,
  input  wire logic block_protect_hi_i,
  input  wire logic block_protect_lo_i,
  input  wire logic nv_lock_i,
  output logic      write_enable_latch_o,
  output logic      write_in_progress_o,
  output logic      sector_locked_o
);

  // UID_VALUE default is arbitrary; each part is given its own at build

  function automatic ssu_pkg::ssu_mode_t ssu_decode(input logic [7:0] op, input logic [1:0] sel);
    ssu_pkg::ssu_mode_t m;
    m = ssu_pkg::SSU_MODE_NONE;
    if (op == ssu_pkg::OP_SECTOR_READ) begin
      if (sel[0]) begin
        m = ssu_pkg::SSU_MODE_UID_RD;
      end else if (sel == ssu_pkg::SEL_SECTOR) begin
        m = ssu_pkg::SSU_MODE_SEC_RD;
      end else begin
        m = ssu_pkg::SSU_MODE_LOCK_RD;
      end
    end else if (op == ssu_pkg::OP_SECTOR_WRITE) begin
      if (sel == ssu_pkg::SEL_SECTOR) begin
        m = ssu_pkg::SSU_MODE_SEC_WR;
      end else if (sel == ssu_pkg::SEL_LOCK) begin
        m = ssu_pkg::SSU_MODE_LOCK_WR;
      end else begin
        m = ssu_pkg::SSU_MODE_NONE;
      end
    end
    return m;
  endfunction : ssu_decode

  function automatic logic [7:0] ssu_uid_byte(input logic [127:0] unique_serial_number, input logic [3:0] idx);
    logic [7:0] b;
    b = unique_serial_number[8'(127 - 8 * int'(idx)) -: 8];
    return b;
  endfunction : ssu_uid_byte

  // Link side: frame state is cleared by chip select, results are not
  logic spi_rst;
  assign spi_rst = reset_i | spi_cs_n_i;

  logic                started_q;
  logic                frame_tog_q;
  logic [5:0]          cnt_q;
  logic [2:0]          phase_q;
  logic [14:0]         sh_q;
  logic [7:0]          op_q;
  logic                busy_hit_q;
  ssu_pkg::ssu_mode_t  mode_q;
  logic [4:0]          ptr_q;
  logic [7:0]          last_byte_q;
  logic [31:0]         mask_q;
  logic [7:0]          buf_mem [ssu_pkg::SECTOR_BYTES];
  logic                wip_s;
  logic                lock_s;

  logic [5:0] idx;
  logic [2:0] ph;
  logic [7:0] in_byte;
  logic       byte_done;
  assign idx       = started_q ? cnt_q : 6'h00;
  assign ph        = started_q ? phase_q : 3'h0;
  assign in_byte   = {sh_q[6:0], serial_in_i};
  assign byte_done = (idx >= ssu_pkg::CNT_HEADER) && (ph == ssu_pkg::PHASE_LAST);

  ssu_sync #(.RESET_VAL(1'b0)) u_wip_sync (
    .clk_i   (spi_clk_i),
    .reset_i (reset_i),
    .level_i (write_in_progress_o),
    .level_o (wip_s)
  );

  ssu_sync #(.RESET_VAL(1'b0)) u_lock_sync (
    .clk_i   (spi_clk_i),
    .reset_i (reset_i),
    .level_i (sector_locked_o),
    .level_o (lock_s)
  );

  always_ff @(posedge spi_clk_i or posedge spi_rst) begin
    if (spi_rst) begin
      started_q <= 1'b0;
      sh_q      <= 15'h0000;
    end else begin
      started_q <= 1'b1;
      sh_q      <= {sh_q[13:0], serial_in_i};
    end
  end

  // Bit count and results survive chip select so the system side can judge them
  always_ff @(posedge spi_clk_i or posedge reset_i) begin
    if (reset_i) begin
      frame_tog_q <= 1'b0;
      cnt_q       <= 6'h00;
      phase_q     <= 3'h0;
      op_q        <= 8'h00;
      busy_hit_q  <= 1'b0;
      last_byte_q <= 8'h00;
    end else if (!spi_cs_n_i) begin
      if (!started_q) begin
        frame_tog_q <= ~frame_tog_q;
        op_q        <= 8'h00;
        busy_hit_q  <= 1'b0;
      end
      cnt_q   <= (idx == ssu_pkg::CNT_SAT) ? idx : idx + 6'h01;
      phase_q <= ph + 3'h1;
      if (idx == ssu_pkg::CNT_OPCODE) begin
        op_q       <= in_byte;
        busy_hit_q <= wip_s;
      end
      if (byte_done) begin
        last_byte_q <= in_byte;
      end
    end
  end

  always_ff @(posedge spi_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_q <= ssu_pkg::SSU_MODE_NONE;
      ptr_q  <= 5'h00;
      mask_q <= 32'h0000_0000;
    end else if (!spi_cs_n_i) begin
      if (!started_q) begin
        mode_q <= ssu_pkg::SSU_MODE_NONE;
        mask_q <= 32'h0000_0000;
      end else if (idx == ssu_pkg::CNT_ADDR) begin
        mode_q <= busy_hit_q ? ssu_pkg::SSU_MODE_NONE : ssu_decode(op_q, sh_q[9:8]);
        ptr_q  <= {sh_q[3:0], serial_in_i};
      end else if (byte_done) begin
        unique case (mode_q)
          ssu_pkg::SSU_MODE_SEC_WR: begin
            mask_q[ptr_q] <= 1'b1;
            ptr_q         <= ptr_q + 5'h01;
          end
          ssu_pkg::SSU_MODE_SEC_RD: ptr_q <= ptr_q + 5'h01;
          ssu_pkg::SSU_MODE_UID_RD: ptr_q <= {1'b0, ptr_q[3:0] + 4'h1};
          ssu_pkg::SSU_MODE_NONE,
          ssu_pkg::SSU_MODE_LOCK_RD,
          ssu_pkg::SSU_MODE_LOCK_WR: ptr_q <= ptr_q;
        endcase
      end
    end
  end

  // Staging buffer; touched by any frame decoded as a sector write, accepted or not
  always_ff @(posedge spi_clk_i) begin
    if (!spi_cs_n_i && started_q && byte_done && mode_q == ssu_pkg::SSU_MODE_SEC_WR) begin
      buf_mem[ptr_q] <= in_byte;
    end
  end

  // Output on falling edges
  logic [7:0] sector_mem [ssu_pkg::SECTOR_BYTES];
  logic       rd_act;
  logic [7:0] rd_byte;

  assign rd_act = started_q && (cnt_q >= ssu_pkg::CNT_HEADER) &&
                  (mode_q == ssu_pkg::SSU_MODE_SEC_RD || mode_q == ssu_pkg::SSU_MODE_LOCK_RD ||
                   mode_q == ssu_pkg::SSU_MODE_UID_RD);

  always_comb begin
    rd_byte = 8'h00;
    unique case (mode_q)
      ssu_pkg::SSU_MODE_SEC_RD:  rd_byte = sector_mem[ptr_q];
      ssu_pkg::SSU_MODE_LOCK_RD: rd_byte[ssu_pkg::LOCK_BIT_POS] = lock_s;
      ssu_pkg::SSU_MODE_UID_RD:  rd_byte = ssu_uid_byte(UID_VALUE, ptr_q[3:0]);
      ssu_pkg::SSU_MODE_NONE,
      ssu_pkg::SSU_MODE_SEC_WR,
      ssu_pkg::SSU_MODE_LOCK_WR: rd_byte = 8'h00;
    endcase
  end

  // Sector memory is only written once chip select has settled high after a frame, so reading it here is safe
  always_ff @(negedge spi_clk_i or posedge spi_rst) begin
    if (spi_rst) begin
      serial_out_o      <= 1'b0;
      serial_out_oe_n_o <= 1'b1;
    end else begin
      serial_out_o      <= rd_act ? rd_byte[~phase_q] : 1'b0;
      serial_out_oe_n_o <= ~rd_act;
    end
  end

  // System side: judge each frame once chip select has settled high
  logic cs_s;
  logic cs_d_q;
  logic seen_tog_q;
  logic frame_end;
  logic new_frame;
  logic protect_all;
  logic cmd_only;
  logic accept_wr;
  logic accept_lock;
  logic start_q;
  logic done;

  ssu_sync #(.RESET_VAL(1'b1)) u_cs_sync (
    .clk_i   (mclk_i),
    .reset_i (reset_i),
    .level_i (spi_cs_n_i),
    .level_o (cs_s)
  );

  assign frame_end   = cs_s && !cs_d_q;
  assign new_frame   = frame_end && (frame_tog_q != seen_tog_q);
  assign protect_all = block_protect_hi_i && block_protect_lo_i;
  assign cmd_only    = (cnt_q == ssu_pkg::CNT_CMD_ONLY);
  assign accept_wr   = new_frame && mode_q == ssu_pkg::SSU_MODE_SEC_WR &&
                       cnt_q >= ssu_pkg::CNT_ONE_BYTE && phase_q == 3'h0 &&
                       write_enable_latch_o && !protect_all && !sector_locked_o &&
                       !write_in_progress_o;
  assign accept_lock = new_frame && mode_q == ssu_pkg::SSU_MODE_LOCK_WR &&
                       cnt_q == ssu_pkg::CNT_ONE_BYTE &&
                       last_byte_q[ssu_pkg::LOCK_BIT_POS] &&
                       write_enable_latch_o && !protect_all && !sector_locked_o &&
                       !write_in_progress_o;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cs_d_q     <= 1'b1;
      seen_tog_q <= 1'b0;
      start_q    <= 1'b0;
    end else begin
      cs_d_q  <= cs_s;
      start_q <= accept_wr || accept_lock;
      if (frame_end) begin
        seen_tog_q <= frame_tog_q;
      end
    end
  end

  // Contents are non-volatile, so the array carries no reset
  always_ff @(posedge mclk_i) begin
    if (accept_wr) begin
      for (int i = 0; i < ssu_pkg::SECTOR_BYTES; i++) begin
        if (mask_q[i]) begin
          sector_mem[i] <= buf_mem[i];
        end
      end
    end
  end

  // Lock only ever sets; the stored copy is folded back in after power-up
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      sector_locked_o <= 1'b0;
    end else if (nv_lock_i || accept_lock) begin
      sector_locked_o <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      write_in_progress_o <= 1'b0;
    end else if (accept_wr || accept_lock) begin
      write_in_progress_o <= 1'b1;
    end else if (done) begin
      write_in_progress_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      write_enable_latch_o <= 1'b0;
    end else if (done) begin
      write_enable_latch_o <= 1'b0;
    end else if (new_frame && cmd_only && !write_in_progress_o) begin
      if (op_q == ssu_pkg::OP_SET_WRITE_LATCH) begin
        write_enable_latch_o <= 1'b1;
      end else if (op_q == ssu_pkg::OP_CLEAR_WRITE_LATCH) begin
        write_enable_latch_o <= 1'b0;
      end
    end
  end

  ssu_timer #(.CYCLES(WRITE_CYCLES)) u_timer (
    .clk_i   (mclk_i),
    .reset_i (reset_i),
    .start_i (start_q),
    .done_o  (done)
  );

endmodule : ssu_top

`default_nettype wire

// ===== tb.sv
// Self-checking bench for the security sector and unique ID block
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int           WC  = 20;
  // Arbitrary number for simulation only
  localparam logic [127:0] UNIQUE_SERIAL_NUMBER = 128'h0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F0;

  typedef struct {logic [15:0] a; logic [15:0] e;} ssu_row_t;

  logic mclk_i, reset_i, spi_clk, spi_cs_n, serial_in, serial_out, oe_n;
  logic bp_hi, bp_lo, nv_lock, write_enable_latch, write_in_progress, locked;
  int   err_count, check_count;
  logic host_miso;

  // Released line shows the inverse of what the block leaves on it, so a missing drive shows up
  assign host_miso = oe_n ? ~serial_out : serial_out;

  ssu_row_t rows [5] = '{'{16'h001E, 16'h1122}, '{16'hE01F, 16'h2233}, '{16'h0200, UNIQUE_SERIAL_NUMBER[127:112]},
                        '{16'hFE0F, {UNIQUE_SERIAL_NUMBER[7:0], UNIQUE_SERIAL_NUMBER[127:120]}}, '{16'h0400, 16'h0000}};

  ssu_top #(.WRITE_CYCLES(WC), .UID_VALUE(UNIQUE_SERIAL_NUMBER)) u_ssu_top (
    .mclk_i(mclk_i), .reset_i(reset_i), .spi_clk_i(spi_clk), .spi_cs_n_i(spi_cs_n),
    .serial_in_i(serial_in), .serial_out_o(serial_out), .serial_out_oe_n_o(oe_n),
    .block_protect_hi_i(bp_hi), .block_protect_lo_i(bp_lo), .nv_lock_i(nv_lock),
    .write_enable_latch_o(write_enable_latch), .write_in_progress_o(write_in_progress), .sector_locked_o(locked));

  ssu_host u_ssu_host (
    .spi_clk_o(spi_clk), .spi_cs_n_o(spi_cs_n), .serial_in_o(serial_in), .serial_out_i(host_miso));

  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask : chk

  // Opcodes with the top bit clear carry no address
  task automatic frame(input logic [7:0] op, input logic [15:0] a, input logic [31:0] d, input int nb,
                       output logic [31:0] q);
    logic [7:0] r;
    u_ssu_host.start();
    u_ssu_host.shift(op, 8, r);
    if (op[7]) begin
      u_ssu_host.shift(a[15:8], 8, r);
      u_ssu_host.shift(a[7:0], 8, r);
    end
    q = 32'h0;
    for (int i = 0; i < nb; i += 8) begin
      u_ssu_host.shift(d[31 - i -: 8], (nb - i < 8) ? nb - i : 8, r);
      q[31 - i -: 8] = r;
    end
    u_ssu_host.stop();
  endtask : frame

  task automatic wait_idle();
    for (int k = 0; k < WC + 10 && write_in_progress === 1'b1; k++) @(posedge mclk_i);
    #1;
    chk(write_in_progress === 1'b0 && write_enable_latch === 1'b0, "write cycle did not end cleanly");
  endtask : wait_idle

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  initial begin
    #100us;
    err_count++;
    wrap_up();
  end

  initial begin
    logic [31:0] q;
    reset_i = 1'b1;
    bp_hi = 1'b0;
    bp_lo = 1'b0;
    nv_lock = 1'b0;
    err_count = 0;
    check_count = 0;
    repeat (6) @(posedge mclk_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    frame(8'h82, 16'h001E, 32'hAA00_0000, 8, q);
    chk(write_in_progress === 1'b0, "write ran without latch");
    frame(8'h06, 16'h0, 32'h0, 0, q);
    chk(write_enable_latch === 1'b1, "latch not set");
    frame(8'h04, 16'h0, 32'h0, 0, q);
    chk(write_enable_latch === 1'b0, "latch not cleared");
    frame(8'h06, 16'h0, 32'h0, 0, q);
    frame(8'h82, 16'hF81E, 32'h1122_3300, 24, q);
    chk(write_in_progress === 1'b1, "write cycle missing");
    frame(8'h83, 16'h001E, 32'h0, 8, q);
    chk(q[31:24] === 8'hFF, "read answered while busy");
    wait_idle();
    $display("test latch and write done");
    foreach (rows[i]) begin
      frame(8'h83, rows[i].a, 32'h0, 16, q);
      chk(q[31:16] === rows[i].e, "read data wrong");
    end
    $display("test read rows done");
    @(posedge mclk_i);
    bp_hi <= 1'b1;
    bp_lo <= 1'b1;
    frame(8'h06, 16'h0, 32'h0, 0, q);
    frame(8'h82, 16'h0400, 32'h0200_0000, 8, q);
    chk(write_in_progress === 1'b0 && locked === 1'b0, "lock under full protection");
    @(posedge mclk_i);
    bp_hi <= 1'b0;
    bp_lo <= 1'b0;
    frame(8'h82, 16'h0400, 32'h0200_0000, 9, q);
    chk(write_in_progress === 1'b0 && locked === 1'b0, "lock with extra bit");
    frame(8'h82, 16'h0200, 32'h0200_0000, 8, q);
    chk(write_in_progress === 1'b0, "unknown select pattern ran");
    $display("test refusals done");
    frame(8'h06, 16'h0, 32'h0, 0, q);
    frame(8'h82, 16'hFDFF, 32'hFE00_0000, 8, q);
    chk(write_in_progress === 1'b1, "lock cycle missing");
    wait_idle();
    chk(locked === 1'b1, "sector not locked");
    frame(8'h83, 16'h0400, 32'h0, 16, q);
    chk(q[31:16] === 16'h0202, "lock status wrong");
    frame(8'h06, 16'h0, 32'h0, 0, q);
    frame(8'h82, 16'h001E, 32'h5500_0000, 8, q);
    chk(write_in_progress === 1'b0, "write ran while locked");
    frame(8'h83, 16'h001E, 32'h0, 8, q);
    chk(q[31:24] === 8'h11, "locked data changed");
    $display("test lock done");
    @(posedge mclk_i);
    reset_i <= 1'b1;
    nv_lock <= 1'b1;
    repeat (6) @(posedge mclk_i);
    chk(write_enable_latch === 1'b0 && write_in_progress === 1'b0 && oe_n === 1'b1, "reset state wrong");
    reset_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    chk(locked === 1'b1, "stored lock lost");
    $display("test reset done");
    wrap_up();
  end
endmodule : tb

`default_nettype wire
